// File: src/pot_pkg.sv
// How it works
// - interface select low gives the 3-wire shift port, high gives the two-wire slave
// - shift word is 10 bits, msb first: two channel bits then 8-bit code
// - with chip select low, each serial clock rising edge shifts in one bit
// - chip select rising edge loads the last 10 bits into the addressed channel
// - channel bits 00,01,10,11 pick channels one to four, upper bit first
// - power-down pin forces the open-drain serial output released (high)
// - clear pin low holds every wiper at midscale; it stays there after release
// - serial output changes on falling clock edge for the next chained device
// - slave address is 01011 followed by the upper and lower strap levels
// - matching address is acknowledged in the ninth clock; 1 means read
// - second written byte is the instruction; msb ignored, next two pick channel
// - instruction midscale bit loads the selected channel with midscale
// - instruction off bit shuts the selected channel, code kept for later
// - power-down pin shuts all channels; off bit only the selected one
// - two bits after the off bit drive the aux outputs; lsb ignored
// - byte after the instruction is the code, acknowledged in the ninth clock
// - read returns the code of the last selected channel right after address ack
// - address plus instruction alone selects the channel for readback
// - further data bytes keep updating; reads repeat; new instruction needs new address
// - a channel off bit is cleared only by reset or by writing it as 0 for that channel
// - reset presets every wiper code to midscale
// - each channel holds an 8-bit code selecting one of 256 taps
package pot_pkg;
  localparam int NUM_CHAN = 4;
  localparam int CHAN_BITS = 2;
  localparam int CODE_BITS = 8;
  localparam int SPI_WORD_BITS = 10;
  localparam int SPI_CHAN_LO = 8;
  localparam int SPI_MSB = 9;
  localparam logic [7:0] MID_CODE = 8'h80;
  localparam logic [4:0] I2C_ADDR_FIXED = 5'h0B;
  localparam int INSTR_CHAN_LO = 5;
  localparam int INSTR_MID_BIT = 4;
  localparam int INSTR_OFF_BIT = 3;
  localparam int INSTR_AUX_ONE_BIT = 2;
  localparam int INSTR_AUX_TWO_BIT = 1;
  localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam int MSB_OF_BYTE = 7;
  // synchronised pin vector layout
  localparam int PIN_COUNT = 10;
  localparam int PIN_SEL = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_CS_N = 2;
  localparam int PIN_SDI = 3;
  localparam int PIN_SCL = 4;
  localparam int PIN_SDA = 5;
  localparam int PIN_PD_N = 6;
  localparam int PIN_CLR_N = 7;
  localparam int PIN_AD_UP = 8;
  localparam int PIN_AD_LO = 9;
  // idle levels: select, cs, scl, sda, power-down and clear rest high
  localparam logic [PIN_COUNT-1:0] PIN_RESET = 10'h0F5;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_INSTR, ST_DATA, ST_READ, ST_IGNORE} i2c_state_type;
endpackage

// File: src/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // clocking
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  initial begin
    if (WIDTH < 1) $error("pin_sync: WIDTH must be at least 1");
  end
  // first stage feeds only the second stage
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta;
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        meta <= RESET_VALUE[i];
        sync_out[i] <= RESET_VALUE[i];
      end else if (clk_en) begin
        meta <= async_in[i];
        sync_out[i] <= meta;
      end
    end
  end
endmodule
`default_nettype wire

// File: src/quad_pot_serial_interface.sv
`timescale 1ns/1ps
`default_nettype none
module quad_pot_serial_interface (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // static control pins
  input wire logic iface_select_pin,
  input wire logic power_down_n_pin,
  input wire logic clear_to_mid_n_pin,
  input wire logic addr_strap_upper,
  input wire logic addr_strap_lower,
  // three-wire shift port
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo_out,
  output logic spi_sdo_oe,
  // two-wire slave port
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // channel state
  output logic [pot_pkg::NUM_CHAN-1:0][pot_pkg::CODE_BITS-1:0] wiper_code,
  output logic [pot_pkg::NUM_CHAN-1:0] channel_shutdown,
  output logic aux_logic_out_one,
  output logic aux_logic_out_two
);
  import pot_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [PIN_COUNT-1:0] pins_raw;
  logic [PIN_COUNT-1:0] pins;
  assign pins_raw[PIN_SEL] = iface_select_pin;
  assign pins_raw[PIN_SCLK] = spi_sclk;
  assign pins_raw[PIN_CS_N] = spi_cs_n;
  assign pins_raw[PIN_SDI] = spi_sdi;
  assign pins_raw[PIN_SCL] = scl_in;
  assign pins_raw[PIN_SDA] = sda_in;
  assign pins_raw[PIN_PD_N] = power_down_n_pin;
  assign pins_raw[PIN_CLR_N] = clear_to_mid_n_pin;
  assign pins_raw[PIN_AD_UP] = addr_strap_upper;
  assign pins_raw[PIN_AD_LO] = addr_strap_lower;

  pin_sync #(.WIDTH(PIN_COUNT), .RESET_VALUE(PIN_RESET)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .async_in(pins_raw),
    .sync_out(pins)
  );

  // delayed copies for edge detection, taken from the second stage
  logic sclk_d;
  logic cs_n_d;
  logic scl_d;
  logic sda_d;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sclk_d <= 1'b0;
      cs_n_d <= 1'b1;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (clk_en) begin
      sclk_d <= pins[PIN_SCLK];
      cs_n_d <= pins[PIN_CS_N];
      scl_d <= pins[PIN_SCL];
      sda_d <= pins[PIN_SDA];
    end
  end

  wire logic i2c_mode = pins[PIN_SEL];
  wire logic spi_mode = ~pins[PIN_SEL];
  wire logic pd_active = ~pins[PIN_PD_N];
  wire logic clr_active = ~pins[PIN_CLR_N];

  // ----------------------------------------
  // three-wire shift port
  // ----------------------------------------
  wire logic spi_rise = spi_mode & pins[PIN_SCLK] & ~sclk_d;
  wire logic spi_fall = spi_mode & ~pins[PIN_SCLK] & sclk_d;
  wire logic spi_sel = ~pins[PIN_CS_N];
  wire logic spi_load = spi_mode & pins[PIN_CS_N] & ~cs_n_d;

  logic [SPI_WORD_BITS-1:0] spi_sr;
  logic sdo_bit;
  wire logic [CHAN_BITS-1:0] spi_ch = spi_sr[SPI_MSB:SPI_CHAN_LO];
  wire logic [CODE_BITS-1:0] spi_data = spi_sr[CODE_BITS-1:0];
  wire logic spi_msb = spi_sr[SPI_MSB];
  wire logic sdi_s = pins[PIN_SDI];

  // only the last ten bits survive the shift, longer frames pass through
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      spi_sr <= '0;
    end else if (clk_en && spi_rise && spi_sel) begin
      spi_sr <= {spi_sr[SPI_WORD_BITS-2:0], sdi_s};
    end
  end

  // bit leaving the register is presented on the falling edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sdo_bit <= 1'b1;
    end else if (clk_en && spi_fall && spi_sel) begin
      sdo_bit <= spi_msb;
    end
  end

  // open drain: only ever pulls low; released while powered down
  assign spi_sdo_out = 1'b0;
  assign spi_sdo_oe = spi_mode & ~pd_active & ~sdo_bit;

  // ----------------------------------------
  // two-wire slave port
  // ----------------------------------------
  wire logic scl_s = pins[PIN_SCL];
  wire logic sda_s = pins[PIN_SDA];
  wire logic scl_rise = scl_s & ~scl_d;
  wire logic scl_fall = ~scl_s & scl_d;
  wire logic i2c_start = scl_s & scl_d & sda_d & ~sda_s;
  wire logic i2c_stop = scl_s & scl_d & ~sda_d & sda_s;

  i2c_state_type state;
  logic [3:0] bit_cnt;
  logic [7:0] rx_sr;
  logic [7:0] tx_sr;
  logic ack_drive;
  logic master_acked;
  logic [CHAN_BITS-1:0] sel_chan;

  wire logic [6:0] own_addr = {I2C_ADDR_FIXED, pins[PIN_AD_UP], pins[PIN_AD_LO]};
  wire logic addr_match = (rx_sr[7:1] == own_addr);
  wire logic rw_read = rx_sr[0];
  wire logic bus_event = i2c_start | i2c_stop;
  wire logic byte_done = i2c_mode & scl_fall & ~bus_event & (bit_cnt == BYTE_LAST_BIT);
  wire logic slot_done = i2c_mode & scl_fall & ~bus_event & (bit_cnt == ACK_SLOT);
  wire logic instr_we = byte_done & (state == ST_INSTR);
  wire logic data_we = byte_done & (state == ST_DATA);
  wire logic mid_we = instr_we & rx_sr[INSTR_MID_BIT];
  wire logic [CHAN_BITS-1:0] instr_ch = rx_sr[INSTR_CHAN_LO+CHAN_BITS-1:INSTR_CHAN_LO];
  wire logic next_ack = ((state == ST_ADDR) & addr_match) | (state == ST_INSTR) | (state == ST_DATA);
  wire logic go_read = slot_done & (((state == ST_ADDR) & addr_match & rw_read) | ((state == ST_READ) & master_acked));

  // next state at the end of each ack slot
  i2c_state_type next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: next_state = ST_IDLE;
      ST_ADDR: next_state = addr_match ? (rw_read ? ST_READ : ST_INSTR) : ST_IGNORE;
      ST_INSTR: next_state = ST_DATA;
      ST_DATA: next_state = ST_DATA;
      ST_READ: next_state = master_acked ? ST_READ : ST_IGNORE;
      ST_IGNORE: next_state = ST_IGNORE;
    endcase
  end

  // a start wins unless interface select is low, so a repeated start re-enters the address phase
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      bit_cnt <= '0;
      ack_drive <= 1'b0;
    end else if (clk_en) begin
      if (!i2c_mode || i2c_stop) begin
        state <= ST_IDLE;
        bit_cnt <= '0;
        ack_drive <= 1'b0;
      end else if (i2c_start) begin
        state <= ST_ADDR;
        // the start's own scl fall is no data bit: it wraps this to zero
        bit_cnt <= '1;
        ack_drive <= 1'b0;
      end else if (scl_fall && state != ST_IDLE) begin
        if (bit_cnt == BYTE_LAST_BIT) begin
          bit_cnt <= ACK_SLOT;
          ack_drive <= next_ack;
        end else if (bit_cnt == ACK_SLOT) begin
          bit_cnt <= '0;
          ack_drive <= 1'b0;
          state <= next_state;
        end else begin
          bit_cnt <= bit_cnt + 4'h1;
        end
      end
    end
  end

  // receive on rising scl; in the read ack slot, sample the master's answer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_sr <= '0;
      master_acked <= 1'b0;
    end else if (clk_en && i2c_mode && scl_rise) begin
      if (bit_cnt < ACK_SLOT) begin
        rx_sr <= {rx_sr[6:0], sda_s};
      end else begin
        master_acked <= ~sda_s;
      end
    end
  end

  // transmit: load right after the ack slot, shift on each falling scl
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_sr <= '1;
    end else if (clk_en) begin
      if (go_read) begin
        tx_sr <= wiper_code[sel_chan];
      end else if (scl_fall && state == ST_READ && bit_cnt < BYTE_LAST_BIT) begin
        tx_sr <= {tx_sr[6:0], 1'b1};
      end
    end
  end

  // instruction side effects; the lsb and the msb are never looked at
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sel_chan <= '0;
      aux_logic_out_one <= 1'b0;
      aux_logic_out_two <= 1'b0;
    end else if (clk_en && instr_we) begin
      sel_chan <= instr_ch;
      aux_logic_out_one <= rx_sr[INSTR_AUX_ONE_BIT];
      aux_logic_out_two <= rx_sr[INSTR_AUX_TWO_BIT];
    end
  end

  wire logic read_drive = (state == ST_READ) & (bit_cnt < ACK_SLOT) & ~tx_sr[MSB_OF_BYTE];
  assign sda_out = 1'b0;
  assign sda_oe = i2c_mode & (ack_drive | read_drive);

  // ----------------------------------------
  // per-channel code and shutdown
  // ----------------------------------------
  logic [NUM_CHAN-1:0] off_bit;
  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
    wire logic hit_spi = spi_load & (spi_ch == CHAN_BITS'(g));
    wire logic hit_mid = mid_we & (instr_ch == CHAN_BITS'(g));
    wire logic hit_data = data_we & (sel_chan == CHAN_BITS'(g));
    wire logic hit_instr = instr_we & (instr_ch == CHAN_BITS'(g));
    // clear holds midscale; no prior code is remembered for after release
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        wiper_code[g] <= MID_CODE;
      end else if (clk_en) begin
        if (clr_active) begin
          wiper_code[g] <= MID_CODE;
        end else if (hit_spi) begin
          wiper_code[g] <= spi_data;
        end else if (hit_mid) begin
          wiper_code[g] <= MID_CODE;
        end else if (hit_data) begin
          wiper_code[g] <= rx_sr;
        end
      end
    end
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        off_bit[g] <= 1'b0;
      end else if (clk_en && hit_instr) begin
        off_bit[g] <= rx_sr[INSTR_OFF_BIT];
      end
    end
  end
  // code register is untouched by shutdown, so exit restores the setting
  assign channel_shutdown = off_bit | {NUM_CHAN{pd_active}};

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_clear_mid;
    clk_en && clr_active |=> (wiper_code == {NUM_CHAN{MID_CODE}});
  endproperty
  a_clear_mid: assert property (p_clear_mid) else $error("clear did not force midscale");

  property p_pd_release;
    pd_active |-> !spi_sdo_oe;
  endproperty
  a_pd_release: assert property (p_pd_release) else $error("sdo pulled while powered down");

  property p_spi_load;
    clk_en && spi_load && !clr_active |=> wiper_code[$past(spi_ch)] == $past(spi_data);
  endproperty
  a_spi_load: assert property (p_spi_load) else $error("chip select rise did not load code");

  property p_spi_shift;
    clk_en && spi_rise && spi_sel |=> spi_sr[0] == $past(sdi_s);
  endproperty
  a_spi_shift: assert property (p_spi_shift) else $error("serial bit not shifted in");

  property p_sdo_fall;
    clk_en && spi_fall && spi_sel |=> sdo_bit == $past(spi_msb) && $stable(spi_sr);
  endproperty
  a_sdo_fall: assert property (p_sdo_fall) else $error("sdo not updated on falling edge");

  property p_addr_ack;
    byte_done && clk_en && state == ST_ADDR && addr_match |=> sda_oe && bit_cnt == ACK_SLOT;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");

  property p_addr_nack;
    byte_done && clk_en && state == ST_ADDR && !addr_match |=> !sda_oe ##1 !ack_drive;
  endproperty
  a_addr_nack: assert property (p_addr_nack) else $error("foreign address acknowledged");

  property p_aux;
    clk_en && instr_we |=> aux_logic_out_one == $past(rx_sr[INSTR_AUX_ONE_BIT])
      && aux_logic_out_two == $past(rx_sr[INSTR_AUX_TWO_BIT]);
  endproperty
  a_aux: assert property (p_aux) else $error("aux outputs not copied from instruction");

  property p_pd_all;
    pd_active |-> (&channel_shutdown);
  endproperty
  a_pd_all: assert property (p_pd_all) else $error("power-down did not shut all channels");

  property p_read_load;
    clk_en && go_read |=> tx_sr == $past(wiper_code[sel_chan]) && state == ST_READ;
  endproperty
  a_read_load: assert property (p_read_load) else $error("read byte not taken from selected channel");

  c_spi_load: cover property (clk_en && spi_load);
  c_i2c_data: cover property (clk_en && data_we);
  c_i2c_read: cover property (clk_en && go_read);
  c_i2c_mid: cover property (clk_en && mid_we);
endmodule
`default_nettype wire

// File: testbench/pot_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pot_host_model (
  // clocking
  input wire logic sys_clk,
  // device drive
  input wire logic spi_sdo_oe,
  input wire logic sda_oe,
  // host drive
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_sdi,
  output logic scl,
  output logic sda
);
  logic sda_low;
  // ----------------------------------------
  // open-drain data line with pull-up
  // ----------------------------------------
  assign sda = !(sda_low || sda_oe);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // quarter of the 80 ns link period, stepped on falling system edges
  task automatic qtr();
    repeat (5) @(negedge sys_clk);
  endtask
  task automatic half();
    qtr();
    qtr();
  endtask
  // ----------------------------------------
  // shift port
  // ----------------------------------------
  // low n bits msb first; sdo level caught at each rising clock
  task automatic spi_frame(input logic [19:0] bits, input int n, output logic [19:0] sdo_seen);
    sdo_seen = '0;
    spi_cs_n = 1'b0;
    for (int k = n - 1; k >= 0; k--) begin
      spi_sdi = bits[k];
      half();
      spi_sclk = 1'b1;
      sdo_seen[k] = !spi_sdo_oe;
      half();
      spi_sclk = 1'b0;
    end
    half();
    spi_cs_n = 1'b1;
    spi_sdi = !spi_sdi;
    half();
  endtask
  // ----------------------------------------
  // two-wire master
  // ----------------------------------------
  // sda moves only mid-low so no false start or stop is seen
  task automatic i2c_bit(input logic b, output logic r);
    qtr();
    sda_low = !b;
    qtr();
    scl = 1'b1;
    half();
    r = sda;
    scl = 1'b0;
  endtask
  task automatic i2c_start();
    qtr();
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
  endtask
  task automatic i2c_stop();
    qtr();
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask
  // last high releases the ninth clock: device ack on write, no-ack on read
  task automatic i2c_byte(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(tx[i], r);
      rx[i] = r;
    end
    i2c_bit(last, r);
    ack = !r;
  endtask
endmodule
`default_nettype wire

// File: testbench/quad_pot_serial_interface_bench.sv
`timescale 1ns/1ps
`default_nettype none
module quad_pot_serial_interface_bench;
  import pot_pkg::*;
  logic sys_clk, rst, iface_select_pin, power_down_n_pin, clear_to_mid_n_pin, strap_up, strap_lo;
  logic spi_sclk, spi_cs_n, spi_sdi, spi_sdo_oe, scl, sda, sda_oe, aux_one, aux_two;
  logic [NUM_CHAN-1:0][CODE_BITS-1:0] wiper_code;
  logic [3:0] channel_shutdown, exp_off;
  logic exp_a1, exp_a2;
  logic clk_en, sdo_drv, sda_drv;
  logic [19:0] frz_seen;
  logic [31:0] rnd;
  logic [6:0] addr;
  int exp_code[4];
  int sel, seed, n_fail, num_checks;
  quad_pot_serial_interface quad_pot_serial_interface_inst (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .iface_select_pin(iface_select_pin),
    .power_down_n_pin(power_down_n_pin), .clear_to_mid_n_pin(clear_to_mid_n_pin),
    .addr_strap_upper(strap_up), .addr_strap_lower(strap_lo), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo_out(sdo_drv), .spi_sdo_oe(spi_sdo_oe),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_drv), .sda_oe(sda_oe), .wiper_code(wiper_code),
    .channel_shutdown(channel_shutdown), .aux_logic_out_one(aux_one), .aux_logic_out_two(aux_two));
  pot_host_model pot_host_model_inst (
    .sys_clk(sys_clk), .spi_sdo_oe(spi_sdo_oe), .sda_oe(sda_oe), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .scl(scl), .sda(sda));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic check_state();
    repeat (8) @(negedge sys_clk);
    for (int ch = 0; ch < 4; ch++) check("wiper code", wiper_code[ch], exp_code[ch]);
    check("channel shutdown", channel_shutdown, exp_off | {4{!power_down_n_pin}});
    check("aux one", aux_one, exp_a1);
    check("aux two", aux_two, exp_a2);
    check("sdo drive level", sdo_drv, 1'b0);
    check("sda drive level", sda_drv, 1'b0);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // transfers with model update
  // ----------------------------------------
  task automatic spi_send(input logic [19:0] bits, input int n);
    logic [19:0] seen;
    pot_host_model_inst.spi_frame(bits, n, seen);
    if (!iface_select_pin) begin
      for (int k = 0; k <= n - 11; k++) begin
        check("sdo level", seen[k], power_down_n_pin ? bits[k+10] : 1'b1);
      end
      if (clear_to_mid_n_pin) exp_code[bits[9:8]] = bits[7:0];
    end
    check_state();
  endtask
  task automatic i2c_wr(input logic [6:0] a, input logic [7:0] ins, input int nd);
    logic [7:0] rx;
    logic ack;
    logic hit;
    hit = (a == {5'b01011, strap_up, strap_lo});
    pot_host_model_inst.i2c_start();
    pot_host_model_inst.i2c_byte({a, 1'b0}, 1'b1, rx, ack);
    check("address ack", ack, hit);
    if (hit) begin
      pot_host_model_inst.i2c_byte(ins, 1'b1, rx, ack);
      check("instruction ack", ack, 1'b1);
      sel = ins[6:5];
      exp_off[sel] = ins[3];
      exp_a1 = ins[2];
      exp_a2 = ins[1];
      if (ins[4]) exp_code[sel] = 128;
      check_state();
      for (int i = 0; i < nd; i++) begin
        rnd = $random(seed);
        pot_host_model_inst.i2c_byte(rnd[7:0], 1'b1, rx, ack);
        check("data ack", ack, 1'b1);
        exp_code[sel] = rnd[7:0];
        check_state();
      end
    end
    pot_host_model_inst.i2c_stop();
    check_state();
  endtask
  task automatic i2c_rd(input int n);
    logic [7:0] rx;
    logic ack;
    pot_host_model_inst.i2c_start();
    pot_host_model_inst.i2c_byte({addr, 1'b1}, 1'b1, rx, ack);
    check("read address ack", ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      pot_host_model_inst.i2c_byte(8'hFF, i == n - 1, rx, ack);
      check("read code", rx, exp_code[sel]);
    end
    pot_host_model_inst.i2c_stop();
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 60;
    rnd = $random(seed);
    {strap_up, strap_lo} = rnd[1:0];
    addr = {5'b01011, rnd[1:0]};
    iface_select_pin = 1'b0;
    clk_en = 1'b1;
    power_down_n_pin = 1'b1;
    clear_to_mid_n_pin = 1'b1;
    rst = 1'b1;
    for (int ch = 0; ch < 4; ch++) exp_code[ch] = 128;
    exp_off = 4'h0;
    exp_a1 = 1'b0;
    exp_a2 = 1'b0;
    sel = 0;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    check_state();
    for (int ch = 0; ch < 4; ch++) begin
      rnd = $random(seed);
      spi_send({rnd[19:10], 2'(ch), rnd[7:0]}, 20);
    end
    // a frame sent while frozen must leave every code alone
    clk_en = 1'b0;
    pot_host_model_inst.spi_frame(20'h001FF, 10, frz_seen);
    clk_en = 1'b1;
    check_state();
    rnd = $random(seed);
    spi_send(rnd[19:0], 13);
    power_down_n_pin = 1'b0;
    rnd = $random(seed);
    spi_send(rnd[19:0], 14);
    power_down_n_pin = 1'b1;
    clear_to_mid_n_pin = 1'b0;
    for (int ch = 0; ch < 4; ch++) exp_code[ch] = 128;
    spi_send(20'h002A5, 10);
    clear_to_mid_n_pin = 1'b1;
    check_state();
    iface_select_pin = 1'b1;
    spi_send(20'h003C3, 10);
    i2c_wr({5'b01011, !strap_up, strap_lo}, 8'h1E, 1);
    for (int ch = 0; ch < 4; ch++) begin
      rnd = $random(seed);
      i2c_wr(addr, {rnd[7], 2'(ch), 1'b0, rnd[3:0]}, 2);
      i2c_rd(2);
    end
    i2c_wr(addr, 8'h51, 0);
    i2c_rd(1);
    i2c_wr(addr, 8'h28, 0);
    i2c_wr(addr, 8'h40, 0);
    i2c_wr(addr, 8'h20, 0);
    i2c_rd(2);
    tally_and_finish();
  end
  initial begin
    repeat (90000) @(posedge sys_clk);
    n_fail++;
    $display("[FAIL] run time expected below limit seen over limit");
    tally_and_finish();
  end
endmodule
`default_nettype wire
